// *** hw/szl_pkg.sv ***
package szl_pkg;

  // data path and program word geometry
  localparam int DW  = 8;
  localparam int PMW = 16;
  localparam int HIW = PMW - DW;
  localparam int PAW = 16;
  localparam int RAW = 8;

  typedef logic [DW-1:0]  szl_byte_t;
  typedef logic [HIW-1:0] szl_high_t;

  localparam szl_byte_t ONE       = 8'h01;
  localparam szl_byte_t ZERO      = 8'h00;
  localparam szl_byte_t RST_BYTE  = 8'h00;
  localparam szl_high_t RST_HIGH  = 8'h00;
  localparam logic [RAW-1:0] RST_RADDR = 8'h00;

  // operations handled by this execution group
  typedef enum logic [2:0]
  {
    SZL_INC_ACC = 3'h0,
    SZL_INC_REG = 3'h1,
    SZL_DEC_ACC = 3'h2,
    SZL_DEC_REG = 3'h3,
    SZL_LOOKUP  = 3'h4
  } szl_op_e;

  // one-hot sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_SKIP = 3'h2,
    ST_LOOK = 3'h4
  } szl_state_e;

endpackage

// *** hw/szl_lookup_if.sv ***
`timescale 1ns/10ps
interface szl_lookup_if;
  import szl_pkg::*;

  logic      start;
  logic      capture;
  szl_byte_t low_byte;

  modport seq
  (
    output start,
    output capture,
    input  low_byte
  );

  modport unit
  (
    input  start,
    input  capture,
    output low_byte
  );
endinterface

// *** hw/szl_lookup.sv ***
`timescale 1ns/10ps
module szl_lookup
  import szl_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         resetn,
  szl_lookup_if.unit        lk,
  input  wire logic         ptr_high_we,
  input  wire logic         ptr_low_we,
  input  wire szl_byte_t    ptr_wdata,
  output logic              pm_rd,
  output logic [PAW-1:0]    pm_addr,
  input  wire [PMW-1:0]     pm_rdata,
  output szl_high_t         lookup_high_byte
);

  szl_byte_t ptr_high_q;
  szl_byte_t ptr_low_q;
  szl_high_t high_q;

  //////////////////////////////////////////////////////////////////////////
  // pointer pair, loaded by software before a lookup
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ptr_high_q <= RST_BYTE;
    else if (ptr_high_we)
      ptr_high_q <= ptr_wdata;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ptr_low_q <= RST_BYTE;
    else if (ptr_low_we)
      ptr_low_q <= ptr_wdata;
  end

  // address is held in flops so the memory sees a stable word address
  assign pm_addr = {ptr_high_q, ptr_low_q};
  assign pm_rd   = lk.start;

  // upper bits of the fetched word land in the dedicated high-byte register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      high_q <= RST_HIGH;
    else if (lk.capture)
      high_q <= pm_rdata[PMW-1:DW];
  end

  assign lookup_high_byte = high_q;
  assign lk.low_byte      = pm_rdata[DW-1:0];

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_ptr_high_load: assert property (ptr_high_we |=> pm_addr[PAW-1:DW] == $past(ptr_wdata))
    else $error("pointer high byte not used as address upper byte");
  a_ptr_low_load: assert property (ptr_low_we |=> pm_addr[DW-1:0] == $past(ptr_wdata))
    else $error("pointer low byte not used as address lower byte");
  a_high_byte_load: assert property (lk.capture |=>
      lookup_high_byte == $past(pm_rdata[PMW-1:DW]))
    else $error("high byte register missed the fetched upper bits");

endmodule

// *** hw/szl_exec.sv ***
`timescale 1ns/10ps
// What this block does
// - increment into accumulator, skip if zero, no flags
// - increment register in place, skip if zero
// - decrement into accumulator, skip if zero, no flags
// - decrement register in place, skip if zero
// - one cycle without skip, two with skip
// - lookup: low byte to register, high bits aside
// - lookup address upper byte from pointer high
// - lookup address lower byte from pointer low
module szl_exec
  import szl_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         op_valid,
  input  wire szl_op_e      op_code,
  input  wire [RAW-1:0]     op_reg_addr,
  input  wire szl_byte_t    op_reg_rdata,
  output logic              op_ready,
  output logic              squash,
  output logic              acc_we,
  output szl_byte_t         acc_wdata,
  output logic              reg_we,
  output logic [RAW-1:0]    reg_waddr,
  output szl_byte_t         reg_wdata,
  input  wire logic         ptr_high_we,
  input  wire logic         ptr_low_we,
  input  wire szl_byte_t    ptr_wdata,
  output logic              pm_rd,
  output logic [PAW-1:0]    pm_addr,
  input  wire [PMW-1:0]     pm_rdata,
  output szl_high_t         lookup_high_byte
);

  szl_state_e     state_q;
  logic           accept;
  logic           is_inc;
  logic           is_incdec;
  logic           to_acc;
  szl_byte_t      result;
  logic           zero;
  logic           acc_we_q;
  szl_byte_t      acc_wdata_q;
  logic           reg_we_q;
  logic [RAW-1:0] reg_waddr_q;
  szl_byte_t      reg_wdata_q;

  szl_lookup_if lk ();

  //////////////////////////////////////////////////////////////////////////
  // decode; a new operation is taken only in the idle state
  // op_reg_rdata must be the current register value in the offer cycle;
  // a write still in flight to the same register is the caller's hazard
  assign accept    = op_valid && (state_q == ST_IDLE);
  assign is_inc    = (op_code == SZL_INC_ACC) || (op_code == SZL_INC_REG);
  assign is_incdec = (op_code != SZL_LOOKUP);
  assign to_acc    = (op_code == SZL_INC_ACC) || (op_code == SZL_DEC_ACC);
  // 8-bit wrap is intended: ff+1 and 01-1 both give zero and skip
  // a lookup also drives result, but is_incdec keeps it from skipping
  assign result    = is_inc ? szl_byte_t'(op_reg_rdata + ONE)
                            : szl_byte_t'(op_reg_rdata - ONE);
  assign zero      = (result == ZERO);

  // ready drops only while the lookup fetch is in flight
  assign op_ready  = (state_q != ST_LOOK);
  // during the skip cycle the fetched instruction is consumed and dropped
  assign squash    = (state_q == ST_SKIP);

  // fetch issued in the offer cycle so the word is back for the look cycle
  assign lk.start   = accept && (op_code == SZL_LOOKUP);
  assign lk.capture = (state_q == ST_LOOK);

  //////////////////////////////////////////////////////////////////////////
  // sequencer: skip adds one dead cycle, lookup always takes two
  //   idle -> skip : zero result taken; the next offer is eaten
  //   idle -> look : fetch issued; memory answers in the look cycle
  //   skip, look   : always back to idle after one cycle
  // op_ready stays high in skip on purpose: the upstream fetch keeps
  // streaming and the dropped word costs nothing extra
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (lk.start)
            state_q <= ST_LOOK;
          else if (accept && is_incdec && zero)
            state_q <= ST_SKIP;
        end
        ST_SKIP: state_q <= ST_IDLE;
        ST_LOOK: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // accumulator write: the source register is left alone, no flag touched
  // data holds its last value; only the strobe says it is new
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_we_q    <= 1'b0;
      acc_wdata_q <= RST_BYTE;
    end
    else
    begin
      acc_we_q <= accept && to_acc;
      if (accept && to_acc)
        acc_wdata_q <= result;
    end
  end

  // register write: in-place results now, lookup low byte one cycle later
  // the address is caught at the offer, so the lookup needs no copy of it
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_we_q    <= 1'b0;
      reg_waddr_q <= RST_RADDR;
      reg_wdata_q <= RST_BYTE;
    end
    else
    begin
      reg_we_q <= (accept && is_incdec && !to_acc) || lk.capture;
      if (accept)
        reg_waddr_q <= op_reg_addr;
      if (lk.capture)
        reg_wdata_q <= lk.low_byte;
      else if (accept)
        reg_wdata_q <= result;
    end
  end

  // outputs straight from flops, so downstream sees no decode glitches
  assign acc_we    = acc_we_q;
  assign acc_wdata = acc_wdata_q;
  assign reg_we    = reg_we_q;
  assign reg_waddr = reg_waddr_q;
  assign reg_wdata = reg_wdata_q;

  //////////////////////////////////////////////////////////////////////////
  szl_lookup u_lookup
  (
    .mclk             (mclk),
    .resetn           (resetn),
    .lk               (lk.unit),
    .ptr_high_we      (ptr_high_we),
    .ptr_low_we       (ptr_low_we),
    .ptr_wdata        (ptr_wdata),
    .pm_rd            (pm_rd),
    .pm_addr          (pm_addr),
    .pm_rdata         (pm_rdata),
    .lookup_high_byte (lookup_high_byte)
  );

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_inc_acc_value: assert property (accept && op_code == SZL_INC_ACC |=>
      acc_we && !reg_we && acc_wdata == szl_byte_t'($past(op_reg_rdata) + ONE))
    else $error("increment to accumulator wrong");
  a_inc_reg_value: assert property (accept && op_code == SZL_INC_REG |=>
      reg_we && !acc_we && reg_waddr == $past(op_reg_addr)
      && reg_wdata == szl_byte_t'($past(op_reg_rdata) + ONE))
    else $error("increment in place wrong");
  a_dec_acc_value: assert property (accept && op_code == SZL_DEC_ACC |=>
      acc_we && !reg_we && acc_wdata == szl_byte_t'($past(op_reg_rdata) - ONE))
    else $error("decrement to accumulator wrong");
  a_dec_reg_value: assert property (accept && op_code == SZL_DEC_REG |=>
      reg_we && !acc_we && reg_waddr == $past(op_reg_addr)
      && reg_wdata == szl_byte_t'($past(op_reg_rdata) - ONE))
    else $error("decrement in place wrong");
  a_skip_two_cycles: assert property (accept && is_incdec && zero |=>
      squash ##1 !squash && op_ready)
    else $error("zero result did not skip exactly one cycle");
  a_no_skip_one: assert property (accept && is_incdec && !zero |=> !squash && op_ready)
    else $error("nonzero result skipped");
  a_lookup_two_cycles: assert property (accept && op_code == SZL_LOOKUP |-> pm_rd ##1
      !op_ready ##1 op_ready && reg_we && reg_wdata == $past(pm_rdata[DW-1:0]))
    else $error("lookup did not finish in two cycles");
  a_squash_no_effect: assert property (squash |=> !acc_we && !reg_we)
    else $error("skipped instruction had an effect");

  // interlocks around the lookup stall: no new fetch, and one cycle only
  a_stall_no_fetch: assert property (!op_ready |-> !pm_rd)
    else $error("fetch started during lookup stall");
  a_stall_single: assert property (!op_ready |=> op_ready)
    else $error("lookup stall longer than one cycle");
  // a lookup never skips and never touches the accumulator
  a_lookup_no_skip: assert property (lk.start |=> !squash ##1 !squash)
    else $error("lookup caused a skip");
  a_lookup_no_acc: assert property (lk.start |=> !acc_we ##1 !acc_we)
    else $error("lookup wrote the accumulator");
  // the low byte goes to the register named when the lookup was taken
  a_lookup_dest: assert property (lk.start |=> ##1 reg_waddr == $past(op_reg_addr, 2))
    else $error("lookup result sent to the wrong register");
  // one destination per operation, so accumulator and register are never written in the same cycle
  a_one_dest: assert property (!(acc_we && reg_we))
    else $error("accumulator and register written together");
  // a skip lasts one cycle; a lookup offered in it must not start a fetch
  a_skip_single: assert property (squash |=> !squash)
    else $error("skip cycle repeated");
  a_skip_no_fetch: assert property (squash |-> !pm_rd)
    else $error("fetch started by a skipped instruction");

  c_skip_taken: cover property (accept && is_incdec && zero);
  c_no_skip:    cover property (accept && is_incdec && !zero);
  c_lookup:     cover property (lk.start ##2 reg_we);
  c_skip_drop:  cover property (squash && op_valid);
  c_stall_hold: cover property (!op_ready && op_valid);

endmodule

// *** bench/tb_skip_on_zero_and_lookup_exec.sv ***
`timescale 1ns/10ps
module tb_skip_on_zero_and_lookup_exec
  import szl_pkg::*;
;
  logic            mclk;
  logic            resetn;
  logic            op_valid;
  szl_op_e         op_code;
  logic [RAW-1:0]  op_reg_addr;
  szl_byte_t       op_reg_rdata;
  logic            op_ready;
  logic            squash;
  logic            acc_we;
  szl_byte_t       acc_wdata;
  logic            reg_we;
  logic [RAW-1:0]  reg_waddr;
  szl_byte_t       reg_wdata;
  logic            ptr_high_we;
  logic            ptr_low_we;
  szl_byte_t       ptr_wdata;
  logic            pm_rd;
  logic [PAW-1:0]  pm_addr;
  logic [PMW-1:0]  pm_rdata;
  szl_high_t       lookup_high_byte;
  int              failures;
  int              comparisons;

  szl_exec uut
  (
    .mclk(mclk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .op_reg_addr(op_reg_addr), .op_reg_rdata(op_reg_rdata), .op_ready(op_ready),
    .squash(squash), .acc_we(acc_we), .acc_wdata(acc_wdata), .reg_we(reg_we),
    .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .ptr_high_we(ptr_high_we),
    .ptr_low_we(ptr_low_we), .ptr_wdata(ptr_wdata), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .lookup_high_byte(lookup_high_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 125 MHz core clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // one compare point so every mismatch is reported the same way
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic op, then a victim increment offered right behind it:
  // the victim must vanish after a skip and run normally otherwise
  task automatic t_arith(input szl_op_e op, input szl_byte_t v);
    logic      to_acc;
    logic      z;
    szl_byte_t exp;
    to_acc = (op == SZL_INC_ACC) || (op == SZL_DEC_ACC);
    exp = (op == SZL_INC_ACC || op == SZL_INC_REG) ? v + ONE : v - ONE;
    z = (exp == ZERO);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= op;
    op_reg_addr <= 8'h21;
    op_reg_rdata <= v;
    @(posedge mclk);
    op_code <= SZL_INC_REG;
    op_reg_addr <= 8'h22;
    op_reg_rdata <= 8'h10;
    #1;
    chk("acc_we", acc_we, to_acc);
    chk("reg_we", reg_we, !to_acc);
    chk("wdata", to_acc ? acc_wdata : reg_wdata, exp);
    if (!to_acc)
      chk("reg_waddr", reg_waddr, 8'h21);
    chk("squash", squash, z);
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
    chk("victim_we", reg_we | acc_we, !z);
    if (!z)
      chk("victim_data", reg_wdata, 8'h11);
    chk("squash_end", squash, 1'b0);
  endtask

  // pointer load, lookup with a stall cycle, word split over two outputs;
  // the memory word is scrambled once its valid cycle is over, and an
  // increment held through the stall must wait and then run once
  task automatic t_lookup(input szl_byte_t hi, input szl_byte_t lo, input logic [15:0] w);
    @(posedge mclk);
    ptr_high_we <= 1'b1;
    ptr_wdata <= hi;
    @(posedge mclk);
    ptr_high_we <= 1'b0;
    ptr_low_we <= 1'b1;
    ptr_wdata <= lo;
    @(posedge mclk);
    ptr_low_we <= 1'b0;
    op_valid <= 1'b1;
    op_code <= SZL_LOOKUP;
    op_reg_addr <= 8'h30;
    #1;
    chk("pm_addr", pm_addr, {hi, lo});
    chk("pm_rd", pm_rd, 1'b1);
    @(posedge mclk);
    op_code <= SZL_INC_ACC;
    op_reg_rdata <= 8'h41;
    pm_rdata <= w;
    #1;
    chk("stall", op_ready, 1'b0);
    chk("early_we", reg_we, 1'b0);
    @(posedge mclk);
    pm_rdata <= ~w;
    #1;
    chk("lk_we", reg_we, 1'b1);
    chk("lk_addr", reg_waddr, 8'h30);
    chk("lk_low", reg_wdata, w[7:0]);
    chk("lk_high", lookup_high_byte, w[15:8]);
    chk("lk_acc", acc_we, 1'b0);
    chk("lk_ready", op_ready, 1'b1);
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
    chk("held_we", acc_we, 1'b1);
    chk("held_data", acc_wdata, 8'h42);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset for 6 cycles, then every arithmetic op with a wrap and a plain value, then two lookups
  initial
  begin
    failures = 0;
    comparisons = 0;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_code = SZL_INC_ACC;
    op_reg_addr = 8'h00;
    op_reg_rdata = 8'h00;
    ptr_high_we = 1'b0;
    ptr_low_we = 1'b0;
    ptr_wdata = 8'h00;
    pm_rdata = 16'h0000;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk("rst_ready", op_ready, 1'b1);
    chk("rst_squash", squash, 1'b0);
    chk("rst_addr", pm_addr, 16'h0000);
    chk("rst_high", lookup_high_byte, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      t_arith(szl_op_e'(i), (i < 2) ? 8'h7F : 8'h00);
      t_arith(szl_op_e'(i), (i < 2) ? 8'hFF : 8'h01);
    end
    t_lookup(8'h01, 8'h15, 16'h1234);
    t_lookup(8'hC3, 8'h5A, 16'h9ABC);
    summarize();
  end

  // watchdog: the whole run needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge mclk);
    failures++;
    summarize();
  end
endmodule
